// File: rtl/adc_output_mode_select.sv
// Functional notes
// - Byte-order select low puts the low byte on lines 7..0 and the high byte on 15..8, high swaps them.
// - Coding select high gives straight binary, low inverts the MSB for twos complement.
// - Fast select high with low-power select low gives the fastest conversion mode.
// - With fast select low, accuracy holds however slowly conversions come.
// - Low-power select high with fast select low gives the reduced-power mode.
// - Port select low uses the parallel port, high uses serial mode and reuses data pins.
// - Data lines 0 and 1 carry result bits 0 and 1 in parallel mode and float in serial mode.
// - In parallel mode data lines 2 and 3 carry result bits 2 and 3.
// - In serial master read-after-convert mode, lines 2 and 3 are a divider input for the serial clock.
// - In all other serial modes the divider pins are held undriven.
// - Divider codes 00, 01, 10, 11 give minimum serial clock periods of 25, 50, 100, 200 ns.
// - Clock-source select low makes the serial clock internal and driven out.
// - In master mode with read-mode select low, a result is shifted only after its conversion completes.
`timescale 1ns/1ps
module adc_output_mode_select
  import adc_mode_pkg::*;
#(
  parameter int FAST_MAX_GAP_CYCLES = FAST_MAX_GAP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] result_data_i,
  input wire logic result_valid_i,
  output logic result_ready_o,
  input wire logic fast_mode_select_i,
  input wire logic low_power_select_i,
  input wire logic output_byte_order_select_i,
  input wire logic binary_coding_select_i,
  input wire logic serial_parallel_select_i,
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic [15:0] data_oe_o,
  output logic serial_clk_o,
  output logic serial_clk_oe_o,
  output logic serial_result_out_o,
  output logic [2:0] speed_mode_o,
  output logic accuracy_risk_o
);
  typedef struct packed {
    ser_state_t state;
    speed_mode_t mode;
    logic [15:0] par_data;
    logic [15:0] shift;
    logic [3:0] bit_cnt;
    logic [2:0] div_cnt;
    logic [2:0] half;
    logic [1:0] serial_clock_divider;
    logic sclk;
    logic ser_bit;
    logic [15:0] gap_cnt;
    logic acc_risk;
  } core_t;

  core_t st_reg;
  core_t st_next;
  logic clock_source_select;
  logic read_mode_or_chain_input;
  logic master_rac;
  logic par_pop;
  logic conv_event;
  logic [15:0] coded;

  result_fifo_if #(.WIDTH(WORD_W)) fifo_bus ();

  result_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .port_if(fifo_bus.fifo)
  );

  // Serial strap inputs shared with data pins
  assign clock_source_select = data_i[PIN_CLK_SRC];
  assign read_mode_or_chain_input = data_i[PIN_READ_MODE];
  assign master_rac = serial_parallel_select_i && !clock_source_select && !read_mode_or_chain_input;

  assign fifo_bus.wr_valid = result_valid_i;
  assign fifo_bus.wr_data = result_data_i;
  assign result_ready_o = fifo_bus.wr_ready;
  assign conv_event = result_valid_i && fifo_bus.wr_ready;
  assign fifo_bus.rd_ready = serial_parallel_select_i ? (master_rac && st_reg.state == SER_IDLE) : 1'b1;
  assign par_pop = !serial_parallel_select_i && fifo_bus.rd_valid;
  assign coded = apply_coding(fifo_bus.rd_data, binary_coding_select_i);

  always_comb begin
    st_next = st_reg;
    if (fast_mode_select_i && !low_power_select_i) begin
      st_next.mode = MODE_FAST;
    end else if (low_power_select_i && !fast_mode_select_i) begin
      st_next.mode = MODE_LOW_POWER;
    end else begin
      st_next.mode = MODE_NORMAL;
    end
    if (par_pop) begin
      st_next.par_data = output_byte_order_select_i ? {coded[BYTE_W-1:0], coded[MSB:BYTE_W]} : coded;
    end
    // gap counted in every mode, risk flagged only in fast mode
    if (conv_event) begin
      st_next.gap_cnt = WORD_RESET;
      st_next.acc_risk = 1'b0;
    end else begin
      if (st_reg.gap_cnt != OE_ALL) begin
        st_next.gap_cnt = 16'(st_reg.gap_cnt + 1'b1);
      end
      if (st_reg.mode == MODE_FAST && st_reg.gap_cnt >= 16'(FAST_MAX_GAP_CYCLES - 1)) begin
        st_next.acc_risk = 1'b1;
      end
    end
    if (st_reg.mode != MODE_FAST) begin
      st_next.acc_risk = 1'b0;
    end
    case (st_reg.state)
      SER_IDLE: begin
        st_next.sclk = 1'b0;
        if (master_rac && fifo_bus.rd_valid) begin
          st_next.state = SER_SHIFT;
          st_next.shift = {coded[MSB-1:0], 1'b0};
          st_next.ser_bit = coded[MSB];
          st_next.bit_cnt = LAST_BIT;
          st_next.div_cnt = '0;
          st_next.serial_clock_divider = data_i[PIN_DIV_HI:PIN_DIV_LO];
          st_next.half = half_cycles(data_i[PIN_DIV_HI:PIN_DIV_LO]);
        end
      end
      SER_SHIFT: begin
        if (!master_rac) begin
          st_next.state = SER_IDLE;
          st_next.sclk = 1'b0;
        end else if (st_reg.div_cnt == 3'(st_reg.half - 1'b1)) begin
          st_next.div_cnt = '0;
          st_next.sclk = ~st_reg.sclk;
          if (st_reg.sclk) begin
            if (st_reg.bit_cnt == BIT_ZERO) begin
              st_next.state = SER_IDLE;
            end else begin
              st_next.ser_bit = st_reg.shift[MSB];
              st_next.shift = {st_reg.shift[MSB-1:0], 1'b0};
              st_next.bit_cnt = 4'(st_reg.bit_cnt - 1'b1);
            end
          end
        end else begin
          st_next.div_cnt = 3'(st_reg.div_cnt + 1'b1);
        end
      end
      default: begin
        st_next.state = SER_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
      st_reg.state <= SER_IDLE;
      st_reg.mode <= MODE_NORMAL;
      st_reg.half <= SCLK_HALF_0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_o = st_reg.par_data;
  assign data_oe_o = serial_parallel_select_i ? OE_SER_DIV_OUT : OE_ALL;
  assign serial_clk_o = st_reg.sclk;
  assign serial_clk_oe_o = serial_parallel_select_i && !clock_source_select;
  assign serial_result_out_o = st_reg.ser_bit;
  assign speed_mode_o = st_reg.mode;
  assign accuracy_risk_o = st_reg.acc_risk;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  a_byte_order_plain: assert property (par_pop && !output_byte_order_select_i |=>
    data_o[7:0] == $past(fifo_bus.rd_data[7:0])) else $error("low byte not on low lines");
  a_byte_order_swap: assert property (par_pop && output_byte_order_select_i |=>
    data_o[15:8] == $past(fifo_bus.rd_data[7:0])) else $error("low byte not on high lines when swapped");
  a_coding_msb_flip: assert property (par_pop && !output_byte_order_select_i |=>
    data_o[15] == ($past(fifo_bus.rd_data[15]) ^ !$past(binary_coding_select_i)))
    else $error("msb coding wrong");
  a_fast_mode_sel: assert property (fast_mode_select_i && !low_power_select_i |=>
    speed_mode_o == MODE_FAST) else $error("fast mode not entered");
  a_low_power_sel: assert property (low_power_select_i && !fast_mode_select_i |=>
    speed_mode_o == MODE_LOW_POWER) else $error("low power mode not entered");
  a_normal_mode_sel: assert property (fast_mode_select_i == low_power_select_i |=>
    speed_mode_o == MODE_NORMAL) else $error("normal mode not entered");
  a_no_risk_slow: assert property (speed_mode_o != MODE_FAST |=> !accuracy_risk_o)
    else $error("accuracy flag outside fast mode");
  a_parallel_drive: assert property (!serial_parallel_select_i |-> data_oe_o == OE_ALL)
    else $error("parallel bus not driven");
  a_low_pins_float: assert property (serial_parallel_select_i |-> data_oe_o[1:0] == 2'h0)
    else $error("low pins driven in serial mode");
  a_div_pins_float: assert property (serial_parallel_select_i |-> data_oe_o[3:2] == 2'h0)
    else $error("divider pins driven in serial mode");
  // Serial clock shape per divider code
  a_sclk_slow_half: assert property ($rose(serial_clk_o) && st_reg.serial_clock_divider == 2'h3
    && master_rac |-> serial_clk_o [*2]) else $error("serial clock high phase too short");
  a_sclk_fast_half: assert property ($rose(serial_clk_o) && st_reg.serial_clock_divider != 2'h3
    |=> !serial_clk_o) else $error("serial clock high phase too long");
  a_sclk_idle_low: assert property (st_reg.state == SER_IDLE |-> !serial_clk_o)
    else $error("serial clock running while idle");
  a_risk_fast_only: assert property ($rose(accuracy_risk_o) |-> $past(speed_mode_o) == MODE_FAST)
    else $error("accuracy flag raised outside fast mode");
  a_shift_needs_rac: assert property (st_reg.state == SER_IDLE && $past(st_reg.state) == SER_IDLE
    && st_next.state == SER_SHIFT |-> master_rac && fifo_bus.rd_valid) else $error("shift without result");

  c_parallel_load: cover property (par_pop ##1 !par_pop);
  c_serial_word: cover property (st_reg.state == SER_SHIFT ##1 st_reg.state == SER_IDLE);
  c_fast_risk: cover property ($rose(accuracy_risk_o));
  c_fifo_full: cover property (!result_ready_o);
  c_slow_divider: cover property (st_reg.state == SER_SHIFT && st_reg.serial_clock_divider == 2'h3);
endmodule

// File: rtl/adc_mode_pkg.sv
package adc_mode_pkg;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 50;

  // Minimum internal serial clock periods per divider code
  localparam int SCLK_MIN_PERIOD_NS_0 = 25;
  localparam int SCLK_MIN_PERIOD_NS_1 = 50;
  localparam int SCLK_MIN_PERIOD_NS_2 = 100;
  localparam int SCLK_MIN_PERIOD_NS_3 = 200;
  // Half periods in clock cycles, rounded up
  localparam logic [2:0] SCLK_HALF_0 = 3'((SCLK_MIN_PERIOD_NS_0 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS));
  localparam logic [2:0] SCLK_HALF_1 = 3'((SCLK_MIN_PERIOD_NS_1 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS));
  localparam logic [2:0] SCLK_HALF_2 = 3'((SCLK_MIN_PERIOD_NS_2 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS));
  localparam logic [2:0] SCLK_HALF_3 = 3'((SCLK_MIN_PERIOD_NS_3 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS));

  // Longest spacing between conversions in fast mode
  localparam int FAST_MAX_GAP_NS = 1000000;
  localparam int FAST_MAX_GAP_CYC = FAST_MAX_GAP_NS / CLK_PERIOD_NS;

  // Pin positions on the shared data bus
  localparam int PIN_CLK_SRC = 4;
  localparam int PIN_READ_MODE = 7;
  localparam int PIN_DIV_LO = 2;
  localparam int PIN_DIV_HI = 3;
  localparam int MSB = WORD_W - 1;
  localparam int BYTE_W = 8;

  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] OE_ALL = 16'hffff;
  localparam logic [15:0] OE_SER_DIV_OUT = 16'h0000;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_FAST = 3'b010,
    MODE_LOW_POWER = 3'b100
  } speed_mode_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;

  function automatic logic [2:0] half_cycles(input logic [1:0] code);
    case (code)
      2'h0: half_cycles = SCLK_HALF_0;
      2'h1: half_cycles = SCLK_HALF_1;
      2'h2: half_cycles = SCLK_HALF_2;
      default: half_cycles = SCLK_HALF_3;
    endcase
  endfunction

  function automatic logic [15:0] apply_coding(input logic [15:0] w, input logic straight);
    apply_coding = w;
    apply_coding[MSB] = straight ? w[MSB] : ~w[MSB];
  endfunction
endpackage

// File: rtl/result_fifo_if.sv
`timescale 1ns/1ps
interface result_fifo_if #(parameter int WIDTH = 16);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

// File: rtl/result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  result_fifo_if.fifo port_if
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic do_wr;
  logic do_rd;

  assign port_if.wr_ready = st_reg.count != (AW+1)'(DEPTH);
  assign port_if.rd_valid = st_reg.count != '0;
  assign port_if.rd_data = st_reg.mem[st_reg.rd_ptr];
  assign do_wr = port_if.wr_valid && port_if.wr_ready;
  assign do_rd = port_if.rd_valid && port_if.rd_ready;

  always_comb begin
    st_next = st_reg;
    if (do_wr) begin
      st_next.mem[st_reg.wr_ptr] = port_if.wr_data;
      st_next.wr_ptr = AW'(st_reg.wr_ptr + 1'b1);
    end
    if (do_rd) begin
      st_next.rd_ptr = AW'(st_reg.rd_ptr + 1'b1);
    end
    if (do_wr && !do_rd) begin
      st_next.count = (AW+1)'(st_reg.count + 1'b1);
    end else if (do_rd && !do_wr) begin
      st_next.count = (AW+1)'(st_reg.count - 1'b1);
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// File: testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk_i,
  input wire logic [15:0] data_o,
  input wire logic [15:0] data_oe_o,
  input wire logic [15:0] host_pins_i,
  input wire logic serial_clk_o,
  input wire logic serial_result_out_o,
  output logic [15:0] data_i,
  output logic [15:0] word_o,
  output int words_o,
  output int gap_o
);
  logic clk_q = 1'b0;
  logic [15:0] shift_q = 16'h0000;
  int bits_q = 0;
  int cyc_q = 0;
  int rise_q = 0;
  // divider straps: host drives only where the device does not
  assign data_i = (data_oe_o & data_o) | (~data_oe_o & host_pins_i);
  initial begin
    word_o = 16'h0000;
    words_o = 0;
    gap_o = 0;
  end
  // Sample serial data at each rising serial clock, MSB first
  always @(posedge sys_clk_i) begin
    cyc_q <= cyc_q + 1;
    clk_q <= serial_clk_o;
    if (serial_clk_o === 1'b1 && clk_q === 1'b0) begin
      gap_o <= cyc_q - rise_q;
      rise_q <= cyc_q;
      shift_q <= {shift_q[14:0], serial_result_out_o};
      bits_q <= (bits_q == 15) ? 0 : bits_q + 1;
      if (bits_q == 15) begin
        word_o <= {shift_q[14:0], serial_result_out_o};
        words_o <= words_o + 1;
      end
    end
  end
endmodule

// File: testbench/adc_output_mode_select_tb_top.sv
`timescale 1ns/1ps
module adc_output_mode_select_tb_top;
  logic sys_clk_i = 1'b0, resetn_i = 1'b0, result_valid_i = 1'b0, result_ready_o;
  logic fast_i = 1'b0, lowp_i = 1'b0, swap_i = 1'b0, coding_i = 1'b1, ser_i = 1'b0;
  logic [15:0] result_data_i = 16'h0000, data_i, data_o, data_oe_o, host_pins, word;
  logic serial_clk_o, serial_clk_oe_o, serial_result_out_o, accuracy_risk_o;
  logic [2:0] speed_mode_o;
  int n_mismatch = 0, check_count = 0, words, gap;
  always #25 sys_clk_i = ~sys_clk_i;
  adc_output_mode_select #(.FAST_MAX_GAP_CYCLES(20)) DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .result_data_i(result_data_i), .result_valid_i(result_valid_i), .result_ready_o(result_ready_o),
    .fast_mode_select_i(fast_i), .low_power_select_i(lowp_i), .output_byte_order_select_i(swap_i),
    .binary_coding_select_i(coding_i), .serial_parallel_select_i(ser_i), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .serial_clk_o(serial_clk_o), .serial_clk_oe_o(serial_clk_oe_o),
    .serial_result_out_o(serial_result_out_o), .speed_mode_o(speed_mode_o), .accuracy_risk_o(accuracy_risk_o));
  host_model host (.sys_clk_i(sys_clk_i), .data_o(data_o), .data_oe_o(data_oe_o), .host_pins_i(host_pins),
    .serial_clk_o(serial_clk_o), .serial_result_out_o(serial_result_out_o), .data_i(data_i), .word_o(word),
    .words_o(words), .gap_o(gap));
  function automatic logic [15:0] coded(input logic [15:0] w, input logic straight, input logic sw);
    logic [15:0] c;
    c = w;
    c[15] = w[15] ^ ~straight;
    return sw ? {c[7:0], c[15:8]} : c;
  endfunction
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic push(input logic [15:0] w);
    int n = 0;
    @(negedge sys_clk_i);
    result_data_i = w;
    result_valid_i = 1'b1;
    while (result_ready_o !== 1'b1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("push wait", 16'(n == 100), 16'h0000);
    @(negedge sys_clk_i);
    result_valid_i = 1'b0;
  endtask
  task automatic wait_words(input int target);
    int n = 0;
    while (words < target && n < 2000) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk("word count", 16'(words), 16'(target));
  endtask
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    // About ten times the planned run
    #500000;
    n_mismatch++;
    test_done();
  end
  initial begin
    logic [15:0] w;
    logic [15:0] modes [4];
    logic [15:0] pins [3];
    modes = '{16'h0001, 16'h0002, 16'h0004, 16'h0001};
    pins = '{16'h0010, 16'h0080, 16'h0090};
    host_pins = 16'h0000;
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    resetn_i = 1'b1;
    chk("reset mode", {13'h0, speed_mode_o}, 16'h0001);
    chk("reset ready", {15'h0, result_ready_o}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      fast_i = i[0];
      lowp_i = i[1];
      repeat (2) @(negedge sys_clk_i);
      chk("speed", {13'h0, speed_mode_o}, modes[i]);
    end
    for (int i = 0; i < 4; i++) begin
      swap_i = i[0];
      coding_i = i[1];
      w = {i[0], 15'h3c81};
      push(w);
      repeat (2) @(negedge sys_clk_i);
      chk("parallel", data_o, coded(w, coding_i, swap_i));
      chk("par oe", data_oe_o, 16'hffff);
    end
    // fast mode spacing kept short, then one long gap
    fast_i = 1'b1;
    lowp_i = 1'b0;
    push(16'h0001);
    repeat (3) @(negedge sys_clk_i);
    chk("risk early", {15'h0, accuracy_risk_o}, 16'h0000);
    repeat (25) @(negedge sys_clk_i);
    chk("risk late", {15'h0, accuracy_risk_o}, 16'h0001);
    push(16'h0002);
    repeat (2) @(negedge sys_clk_i);
    chk("risk clear", {15'h0, accuracy_risk_o}, 16'h0000);
    fast_i = 1'b0;
    repeat (30) @(negedge sys_clk_i);
    chk("risk normal", {15'h0, accuracy_risk_o}, 16'h0000);
    coding_i = 1'b0;
    ser_i = 1'b1;
    for (int d = 0; d < 4; d++) begin
      host_pins = 16'(d << 2);
      w = 16'h9a35 ^ 16'(d);
      push(w);
      wait_words(d + 1);
      chk("serial word", word, coded(w, 1'b0, 1'b0));
      chk("sclk period", 16'(gap), (d == 3) ? 16'h0004 : 16'h0002);
      chk("ser oe", data_oe_o, 16'h0000);
      chk("sclk oe", {15'h0, serial_clk_oe_o}, 16'h0001);
    end
    for (int i = 0; i < 3; i++) begin
      host_pins = pins[i];
      @(negedge sys_clk_i);
      chk("other oe", data_oe_o, 16'h0000);
      chk("other sclk oe", {15'h0, serial_clk_oe_o}, {15'h0, ~pins[i][4]});
    end
    host_pins = 16'h0010;
    for (int i = 0; i < 16; i++) begin
      push(16'h1000 + 16'(i));
    end
    chk("full", {15'h0, result_ready_o}, 16'h0000);
    host_pins = 16'h0000;
    wait_words(20);
    chk("drained word", word, coded(16'h100f, 1'b0, 1'b0));
    chk("empty", {15'h0, result_ready_o}, 16'h0001);
    test_done();
  end
endmodule
